// ==== rtl/sdc_conversion_control.sv ====
// Conversion control: setup registers, rate timing, settling, sweep and data-ready
`timescale 1ns/1ps
`include "sdc_defines.svh"
module sdc_conversion_control
	import sdc_pkg::*;
#(
	parameter int unsigned PER_LOW_FS0  = `SDC_PER_LOW_FS0,
	parameter int unsigned PER_LOW_FS1  = `SDC_PER_LOW_FS1,
	parameter int unsigned PER_LOW_FS2  = `SDC_PER_LOW_FS2,
	parameter int unsigned PER_LOW_FS3  = `SDC_PER_LOW_FS3,
	parameter int unsigned PER_HIGH_FS0 = `SDC_PER_HIGH_FS0,
	parameter int unsigned PER_HIGH_FS1 = `SDC_PER_HIGH_FS1,
	parameter int unsigned PER_HIGH_FS2 = `SDC_PER_HIGH_FS2,
	parameter int unsigned PER_HIGH_FS3 = `SDC_PER_HIGH_FS3
) (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       masterClockInput,
	input  wire logic       regWrite,
	input  wire logic [2:0] regSelect,
	input  wire logic [7:0] regWrData,
	input  wire logic       filterSyncHold,
	input  wire logic       dataReadDone,
	output logic      [7:0] setupPrimary,
	output logic      [7:0] setupSecondary,
	output logic            dataReadyFlag,
	output logic            dataReadyIntN,
	output logic            resultStore,
	output logic      [2:0] convChannel,
	output logic      [1:0] transferSelect,
	output logic            modulatorReset,
	output logic            thirdOrderSinc,
	output logic            inputBufferEnable,
	output logic            burnoutCurrentEnable
);

	// Output period in master clock ticks, before the modulator ratio shift
	function automatic sdc_count_t basePeriod(input logic clkRate, input logic [1:0] decim);
		int unsigned p;
		p = 0;
		unique case ({clkRate, decim})
			3'h0: p = PER_LOW_FS0;
			3'h1: p = PER_LOW_FS1;
			3'h2: p = PER_LOW_FS2;
			3'h3: p = PER_LOW_FS3;
			3'h4: p = PER_HIGH_FS0;
			3'h5: p = PER_HIGH_FS1;
			3'h6: p = PER_HIGH_FS2;
			3'h7: p = PER_HIGH_FS3;
		endcase
		return sdc_count_t'(p);
	endfunction

	// Input index to transfer-function register
	function automatic logic [1:0] mapInput(input logic [2:0] idx, input logic differential_select);
		if (differential_select)
			return idx[1:0];
		else if (idx < 3'h2)
			return 2'h0;
		else if (idx < 3'h4)
			return 2'h1;
		else
			return 2'h2;
	endfunction

	localparam sdc_chan_t CH_OFFSET_CAL = 3'h5;
	localparam sdc_chan_t CH_GAIN_CAL   = 3'h6;

	logic       [7:0] primary_ff;
	logic       [7:0] secondary_ff;
	logic             clkSync1_ff;
	logic             clkSync2_ff;
	logic             clkSync3_ff;
	logic             halfPhase_ff;
	logic             masterTick;
	sdc_count_t       periodCnt_ff;
	sdc_count_t       periodLen;
	logic       [1:0] settleCnt_ff;
	logic       [1:0] settleNeed;
	sdc_state_e       state_ff;
	sdc_state_e       nxt_state;
	sdc_chan_t        chan_ff;
	sdc_chan_t        nxt_chan;
	sdc_chan_t        selChan;
	sdc_chan_t        lastInput;
	logic             calEnabled;
	logic             writePrimary;
	logic             writeSecondary;
	logic             configChange;
	logic             sampleDone;
	logic             storeNow;
	logic             dataReady_ff;

	wire logic       scanOn    = secondary_ff[`SDC_S_SCAN];
	wire logic [1:0] calMode   = secondary_ff[`SDC_S_CALMODE];
	wire logic       diffOn    = secondary_ff[`SDC_S_DIFFERENTIAL_SELECT];
	wire logic [1:0] chanField = primary_ff[`SDC_P_CHSEL];

	assign writePrimary   = regWrite && (regSelect == `SDC_REG_PRIMARY);
	assign writeSecondary = regWrite && (regSelect == `SDC_REG_SECONDARY);
	// Reserved bit is forced to zero; the host is expected to write zero anyway
	assign configChange   = (writePrimary && (regWrData != primary_ff))
		|| (writeSecondary && ((regWrData & 8'hFD) != secondary_ff));

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			primary_ff   <= `SDC_PRIMARY_RESET;
			secondary_ff <= `SDC_SECONDARY_RESET;
		end else begin
			if (writePrimary)
				primary_ff <= regWrData;
			if (writeSecondary)
				secondary_ff <= regWrData & 8'hFD;
		end
	end

	// Master clock pin: three flops, then edge detect on the later pair
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			clkSync1_ff <= 1'b0;
			clkSync2_ff <= 1'b0;
			clkSync3_ff <= 1'b0;
		end else begin
			clkSync1_ff <= masterClockInput;
			clkSync2_ff <= clkSync1_ff;
			clkSync3_ff <= clkSync2_ff;
		end
	end

	// Prescaler passes every second master edge when halving is on
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			halfPhase_ff <= 1'b0;
		else if (!secondary_ff[`SDC_S_HALVING])
			halfPhase_ff <= 1'b0;
		else if (clkSync2_ff && !clkSync3_ff)
			halfPhase_ff <= !halfPhase_ff;
	end

	assign masterTick = clkSync2_ff && !clkSync3_ff
		&& (!secondary_ff[`SDC_S_HALVING] || halfPhase_ff);

	// Modulator ratio steps halve the period, doubling the output rate
	assign periodLen = basePeriod(primary_ff[`SDC_P_CLKRATE], primary_ff[`SDC_P_DECIM])
		>> primary_ff[`SDC_P_MODRATIO];
	// Hold and setup changes beat a sample in the same cycle: stale data never stores
	assign sampleDone = (state_ff == SDC_CONVERT) && masterTick
		&& !filterSyncHold && !configChange
		&& (periodCnt_ff >= periodLen - 16'h1);

	// Settling depth depends on filter order
	assign settleNeed = primary_ff[`SDC_P_FAST] ? `SDC_SETTLE_FIRST : `SDC_SETTLE_THIRD;
	assign storeNow   = sampleDone && (settleCnt_ff + 2'h1 >= settleNeed);

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			SDC_HELD:
				if (!filterSyncHold)
					nxt_state = SDC_CONVERT;
			SDC_CONVERT:
				if (filterSyncHold)
					nxt_state = SDC_HELD;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			state_ff <= SDC_HELD;
		else
			state_ff <= nxt_state;
	end

	// Period and settle counters restart on hold or on any setup change
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			periodCnt_ff <= 16'h0000;
			settleCnt_ff <= 2'h0;
		end else if (filterSyncHold || configChange || state_ff == SDC_HELD) begin
			periodCnt_ff <= 16'h0000;
			settleCnt_ff <= 2'h0;
		end else if (sampleDone) begin
			periodCnt_ff <= 16'h0000;
			if (storeNow && scanOn)
				settleCnt_ff <= 2'h0;
			else if (!storeNow)
				settleCnt_ff <= settleCnt_ff + 2'h1;
		end else if (masterTick) begin
			periodCnt_ff <= periodCnt_ff + 16'h0001;
		end
	end

	assign calEnabled = calMode[0] ^ calMode[1];
	assign lastInput  = diffOn ? 3'h2 : 3'h4;
	always_comb begin
		if (calMode == 2'b01)
			selChan = CH_OFFSET_CAL;
		else if (calMode == 2'b10)
			selChan = CH_GAIN_CAL;
		else
			selChan = {1'b0, chanField};
	end

	always_comb begin
		nxt_chan = chan_ff;
		// Sweep restarts at the first input on a change while sweeping or when it starts
		if (configChange && (scanOn || (writeSecondary && regWrData[`SDC_S_SCAN])))
			nxt_chan = 3'h0;
		else if (!scanOn)
			nxt_chan = selChan;
		else if (storeNow) begin
			if (chan_ff == CH_OFFSET_CAL)
				nxt_chan = CH_GAIN_CAL;
			else if (chan_ff == CH_GAIN_CAL)
				nxt_chan = 3'h0;
			else if (chan_ff >= lastInput)
				nxt_chan = calEnabled ? CH_OFFSET_CAL : 3'h0;
			else
				nxt_chan = chan_ff + 3'h1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			chan_ff <= 3'h0;
		else
			chan_ff <= nxt_chan;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			transferSelect <= 2'h0;
		else if (nxt_chan < CH_OFFSET_CAL)
			transferSelect <= mapInput(nxt_chan, diffOn);
		else if (scanOn)
			transferSelect <= 2'h2;
		else
			transferSelect <= mapInput({1'b0, chanField}, diffOn);
	end

	// Set wins over a read completing in the same cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			dataReady_ff <= 1'b0;
		else if (storeNow)
			dataReady_ff <= 1'b1;
		else if (configChange || dataReadDone)
			dataReady_ff <= 1'b0;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			resultStore          <= 1'b0;
			modulatorReset       <= 1'b1;
			thirdOrderSinc       <= 1'b1;
			inputBufferEnable    <= 1'b0;
			burnoutCurrentEnable <= 1'b0;
		end else begin
			resultStore          <= storeNow;
			modulatorReset       <= filterSyncHold || configChange;
			thirdOrderSinc       <= !primary_ff[`SDC_P_FAST];
			inputBufferEnable    <= secondary_ff[`SDC_S_BUFFER];
			burnoutCurrentEnable <= secondary_ff[`SDC_S_BURNOUT];
		end
	end

	assign setupPrimary   = primary_ff;
	assign setupSecondary = secondary_ff;
	assign dataReadyFlag  = dataReady_ff;
	assign convChannel    = chan_ff;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			dataReadyIntN <= 1'b1;
		else
			dataReadyIntN <= !(storeNow || (dataReady_ff && !configChange && !dataReadDone));
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	property p_holdResets;
		filterSyncHold |=> modulatorReset && !resultStore;
	endproperty
	a_holdResets: assert property (p_holdResets)
		else $error("hold did not reset modulator");

	property p_holdKeepsReady;
		filterSyncHold && dataReadyFlag && !dataReadDone && !configChange |=> dataReadyFlag;
	endproperty
	a_holdKeepsReady: assert property (p_holdKeepsReady)
		else $error("hold cleared data-ready");

	property p_readClears;
		dataReadDone && !storeNow |=> !dataReadyFlag;
	endproperty
	a_readClears: assert property (p_readClears)
		else $error("data read did not clear data-ready");

	property p_changeDrops;
		configChange && !storeNow |=> !dataReadyFlag && modulatorReset
			##1 (!dataReadyFlag || resultStore);
	endproperty
	a_changeDrops: assert property (p_changeDrops)
		else $error("setup change kept data-ready");

	property p_thirdSettles;
		storeNow && !primary_ff[`SDC_P_FAST] |-> settleCnt_ff == 2'h2 || !scanOn && settleCnt_ff == 2'h2;
	endproperty
	a_thirdSettles: assert property (p_thirdSettles)
		else $error("third-order result before three samples");

	property p_sweepOrder;
		scanOn && !configChange && storeNow && chan_ff == CH_OFFSET_CAL |=> convChannel == CH_GAIN_CAL;
	endproperty
	a_sweepOrder: assert property (p_sweepOrder)
		else $error("gain calibration did not follow offset");

	property p_sweepRange;
		scanOn && $past(scanOn) && !$past(configChange) && calMode == 2'b00
			|-> convChannel <= (diffOn ? 3'h2 : 3'h4);
	endproperty
	a_sweepRange: assert property (p_sweepRange)
		else $error("sweep left its channel range");

	property p_fieldIgnored;
		scanOn && !storeNow && !configChange |=> $stable(convChannel);
	endproperty
	a_fieldIgnored: assert property (p_fieldIgnored)
		else $error("channel moved without a stored result");

	property p_singleChannel;
		!scanOn && calMode == 2'b00 ##1 !scanOn |-> convChannel == {1'b0, $past(chanField)};
	endproperty
	a_singleChannel: assert property (p_singleChannel)
		else $error("single mode converts wrong channel");

	property p_bufferFollows;
		##1 inputBufferEnable == $past(secondary_ff[`SDC_S_BUFFER]);
	endproperty
	a_bufferFollows: assert property (p_bufferFollows)
		else $error("buffer enable does not follow setup");

endmodule

// ==== rtl/sdc_defines.svh ====
// Constants of the sigma-delta conversion control block
`ifndef SDC_DEFINES_SVH
`define SDC_DEFINES_SVH

`define SDC_REG_PRIMARY        3'h1
`define SDC_REG_SECONDARY      3'h2
`define SDC_PRIMARY_RESET      8'h0A
`define SDC_SECONDARY_RESET    8'h00

`define SDC_P_CHSEL            7:6
`define SDC_P_MODRATIO         5:4
`define SDC_P_CLKRATE          3
`define SDC_P_DECIM            2:1
`define SDC_P_FAST             0
`define SDC_S_SCAN             7
`define SDC_S_CALMODE          6:5
`define SDC_S_BUFFER           4
`define SDC_S_DIFFERENTIAL_SELECT             3
`define SDC_S_BURNOUT          2
`define SDC_S_RESERVED         1
`define SDC_S_HALVING          0

`define SDC_SETTLE_THIRD       2'h3
`define SDC_SETTLE_FIRST       2'h1

`define SDC_PER_LOW_FS0        51200
`define SDC_PER_LOW_FS1        40960
`define SDC_PER_LOW_FS2        10240
`define SDC_PER_LOW_FS3        5120
`define SDC_PER_HIGH_FS0       49152
`define SDC_PER_HIGH_FS1       40960
`define SDC_PER_HIGH_FS2       8192
`define SDC_PER_HIGH_FS3       4096

`endif

// ==== rtl/sdc_pkg.sv ====
// Types of the sigma-delta conversion control block
package sdc_pkg;
	typedef enum logic [1:0] {
		SDC_HELD    = 2'b01,
		SDC_CONVERT = 2'b10
	} sdc_state_e;
	typedef logic [2:0] sdc_chan_t;
	typedef logic [15:0] sdc_count_t;
endpackage

// ==== dv/sdc_master_clock_model.sv ====
// Master clock source model feeding the conversion control block
`timescale 1ns/1ps
module sdc_master_clock_model #(
	parameter int HALF = 2
) (
	input  wire logic clk,
	input  wire logic run,
	output logic      masterClockInput,
	output int        tickCount
);
	int div = 0;
	initial begin
		masterClockInput = 1'b0;
		tickCount = 0;
	end
	// Stands still while stopped, so no stray ticks reach the block
	// Moves on the falling edge, clear of the block's sampling edge
	always @(negedge clk) begin
		if (run) begin
			div = div + 1;
			if (div == HALF) begin
				div = 0;
				masterClockInput = !masterClockInput;
				if (masterClockInput)
					tickCount = tickCount + 1;
			end
		end
	end
endmodule

// ==== dv/tb.sv ====
// Testbench of the conversion control block
`timescale 1ns/1ps
module tb;
	import sdc_pkg::*;
	localparam int LO [4] = '{64, 48, 16, 8};
	localparam int HI [4] = '{56, 48, 24, 8};
	logic       clk;
	logic       nrst;
	logic       masterClockInput;
	logic       run;
	logic       regWrite;
	logic [2:0] regSelect;
	logic [7:0] regWrData;
	logic       filterSyncHold;
	logic       dataReadDone;
	logic [7:0] setupPrimary;
	logic [7:0] setupSecondary;
	logic       dataReadyFlag;
	logic       dataReadyIntN;
	logic       resultStore;
	logic [2:0] convChannel;
	logic [1:0] transferSelect;
	logic       modulatorReset;
	logic       thirdOrderSinc;
	logic       inputBufferEnable;
	logic       burnoutCurrentEnable;
	int         tickCount;
	int         errCount = 0;
	int         nTests = 0;
	int         cyc = 0;

	sdc_master_clock_model sdc_master_clock_model_inst (
		.clk              (clk),
		.run              (run),
		.masterClockInput (masterClockInput),
		.tickCount        (tickCount)
	);

	sdc_conversion_control #(
		.PER_LOW_FS0(LO[0]), .PER_LOW_FS1(LO[1]), .PER_LOW_FS2(LO[2]), .PER_LOW_FS3(LO[3]),
		.PER_HIGH_FS0(HI[0]), .PER_HIGH_FS1(HI[1]), .PER_HIGH_FS2(HI[2]), .PER_HIGH_FS3(HI[3])
	) sdc_conversion_control_inst (
		.clk(clk), .nrst(nrst), .masterClockInput(masterClockInput),
		.regWrite(regWrite), .regSelect(regSelect), .regWrData(regWrData),
		.filterSyncHold(filterSyncHold), .dataReadDone(dataReadDone),
		.setupPrimary(setupPrimary), .setupSecondary(setupSecondary),
		.dataReadyFlag(dataReadyFlag), .dataReadyIntN(dataReadyIntN),
		.resultStore(resultStore), .convChannel(convChannel),
		.transferSelect(transferSelect), .modulatorReset(modulatorReset),
		.thirdOrderSinc(thirdOrderSinc), .inputBufferEnable(inputBufferEnable),
		.burnoutCurrentEnable(burnoutCurrentEnable)
	);

	task automatic closeOut;
		$display("comparisons %0d mismatches %0d", nTests, errCount);
		if (errCount == 0 && nTests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		nTests++;
		if (seen !== exp) begin
			errCount++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [2:0] sel, input logic [7:0] d);
		@(negedge clk);
		regWrite = 1'b1;
		regSelect = sel;
		regWrData = d;
		@(negedge clk);
		regWrite = 1'b0;
	endtask

	task automatic rd;
		@(negedge clk);
		dataReadDone = 1'b1;
		@(negedge clk);
		dataReadDone = 1'b0;
	endtask

	// Bounded wait; leaves the caller in the cycle of the store pulse
	task automatic waitStore;
		int n;
		n = 0;
		@(negedge clk);
		while (resultStore !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 3000)
			chk(8'h00, 8'h01);
	endtask

	task automatic measure(input logic [7:0] p1, input int e);
		int t0;
		wr(3'h1, p1);
		waitStore();
		waitStore();
		t0 = tickCount;
		waitStore();
		chk(8'(tickCount - t0), 8'(e));
	endtask

	initial begin
		clk = 1'b0;
		forever #25 clk = !clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			errCount++;
			closeOut();
		end
	end

	initial begin
		int t0;
		int n;
		int e;
		logic [2:0] ch;
		logic [7:0] sv [3];
		logic [4:0] ex [3];
		sv = '{8'h20, 8'h40, 8'h08};
		ex = '{5'h15, 5'h19, 5'h0A};
		nrst = 1'b0;
		run = 1'b1;
		regWrite = 1'b0;
		regSelect = 3'h0;
		regWrData = 8'h00;
		filterSyncHold = 1'b0;
		dataReadDone = 1'b0;
		repeat (4) @(negedge clk);
		chk(setupPrimary, 8'h0A);
		chk(setupSecondary, 8'h00);
		chk({2'h0, dataReadyFlag, dataReadyIntN, modulatorReset, thirdOrderSinc,
			inputBufferEnable, burnoutCurrentEnable}, 8'h1C);
		nrst = 1'b1;
		wr(3'h3, 8'hFF);
		chk(setupPrimary, 8'h0A);
		wr(3'h2, 8'h14);
		@(negedge clk);
		chk({6'h00, inputBufferEnable, burnoutCurrentEnable}, 8'h03);
		wr(3'h2, 8'h00);
		@(negedge clk);
		chk({6'h00, inputBufferEnable, burnoutCurrentEnable}, 8'h00);
		for (int c = 0; c < 2; c++)
			for (int f = 0; f < 4; f++)
				for (int m = 0; m < 4; m += 3)
					measure(8'(m * 16 + c * 8 + f * 2 + 1), (c ? HI[f] : LO[f]) >> m);
		wr(3'h2, 8'h01);
		measure(8'h07, 2 * LO[3]);
		wr(3'h2, 8'h00);
		wr(3'h1, 8'h05);
		waitStore();
		t0 = tickCount;
		wr(3'h1, 8'h04);
		chk({5'h00, dataReadyFlag, dataReadyIntN, modulatorReset}, 8'h03);
		waitStore();
		n = tickCount - t0;
		chk(8'(n >= 3 * LO[2] - 1 && n <= 3 * LO[2] + 1), 8'h01);
		chk({7'h00, thirdOrderSinc}, 8'h01);
		t0 = tickCount;
		wr(3'h1, 8'h05);
		waitStore();
		n = tickCount - t0;
		chk(8'(n >= LO[2] - 1 && n <= LO[2] + 1), 8'h01);
		chk({7'h00, thirdOrderSinc}, 8'h00);
		@(negedge clk);
		chk({6'h00, dataReadyFlag, dataReadyIntN}, 8'h02);
		rd();
		chk({6'h00, dataReadyFlag, dataReadyIntN}, 8'h01);
		waitStore();
		filterSyncHold = 1'b1;
		repeat (2) @(negedge clk);
		chk({7'h00, modulatorReset}, 8'h01);
		n = 0;
		repeat (300) begin
			@(negedge clk);
			if (resultStore === 1'b1)
				n++;
		end
		chk(8'(n), 8'h00);
		chk({7'h00, dataReadyFlag}, 8'h01);
		rd();
		chk({7'h00, dataReadyFlag}, 8'h00);
		filterSyncHold = 1'b0;
		waitStore();
		chk({7'h00, dataReadyFlag}, 8'h01);
		for (int i = 0; i < 3; i++) begin
			wr(3'h1, 8'h85);
			wr(3'h2, sv[i]);
			repeat (2) begin
				waitStore();
				chk({3'h0, convChannel, transferSelect}, {3'h0, ex[i]});
			end
		end
		wr(3'h1, 8'hC7);
		for (int i = 0; i < 6; i++) begin
			n = (i / 3) ? 3 : 5;
			wr(3'h2, 8'(128 + (i % 3) * 32 + (i / 3) * 8));
			@(negedge clk);
			chk({5'h00, convChannel}, 8'h00);
			waitStore();
			ch = convChannel;
			repeat (9) begin
				waitStore();
				e = (ch == ((i % 3) ? 6 : n - 1)) ? 0 : ((ch == n - 1) ? 5 : ch + 1);
				chk({5'h00, convChannel}, 8'(e));
				e = (convChannel > 4) ? 2 : ((i / 3) ? convChannel : convChannel / 2);
				chk({6'h00, transferSelect}, 8'(e));
				ch = convChannel;
			end
		end
		closeOut();
	end
endmodule
